// file: design/epdo_pkg.sv
// Constants shared by the energy pulse digital output block.
// Assumes a 50 MHz core clock and 16-bit parameter words, high word first.
package epdo_pkg;
    // ==========================================================
    // Parameter addresses
    localparam logic [15:0] ADDR_PWR_SEL_ONE = 16'h0064;
    localparam logic [15:0] ADDR_PWR_SEL_TWO = 16'h0065;
    localparam logic [15:0] ADDR_EPP_ONE_HI = 16'h0066;
    localparam logic [15:0] ADDR_EPP_ONE_LO = 16'h0067;
    localparam logic [15:0] ADDR_EPP_TWO_HI = 16'h0068;
    localparam logic [15:0] ADDR_EPP_TWO_LO = 16'h0069;
    localparam logic [15:0] ADDR_PULSE_LEN = 16'h006A;
    localparam logic [15:0] ADDR_SRC_ONE = 16'h00C8;
    localparam logic [15:0] ADDR_SRC_TWO = 16'h00CA;
    localparam logic [15:0] ADDR_STATE_ONE = 16'h0260;
    localparam logic [15:0] ADDR_STATE_TWO = 16'h0261;
    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_PWR_SEL = 16'h0000;
    localparam logic [31:0] RST_EPP = 32'h00000000;
    localparam logic [15:0] RST_PULSE_LEN = 16'h001E;
    localparam logic [15:0] RST_SRC = 16'h0000;
    // ==========================================================
    // Output source codes
    localparam logic [15:0] SRC_COMPARATOR = 16'h0000;
    localparam logic [15:0] SRC_PULSE = 16'h0001;
    localparam logic [15:0] SRC_EXTERNAL = 16'h0002;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] PULSE_LEN_MIN_MS = 16'h000A;
    localparam logic [15:0] PULSE_LEN_MAX_MS = 16'h2710;
    // Energy scale: one pulse-value unit (mWh) equals 3600 W*ms.
    localparam logic [63:0] ENERGY_SCALE = 64'h0000000000000E10;
    localparam int NUM_OUTPUTS = 2;
endpackage

// file: design/epdo_pulse_if.sv
// Carrier between the output controller and one pulse generator.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface epdo_pulse_if;
    logic tick;
    logic signed [31:0] power;
    logic signed [31:0] epp;
    logic [15:0] len_ms;
    logic pulse;
    modport ctl (output tick, output power, output epp, output len_ms, input pulse);
    modport gen (input tick, input power, input epp, input len_ms, output pulse);
endinterface // epdo_pulse_if

// file: design/epdo_pulse_gen.sv
// Energy pulse generator for one digital output.
// Assumes tick is a one-cycle pulse once per millisecond.
`timescale 1ns/1ps
module epdo_pulse_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controller side
    epdo_pulse_if.gen pif
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HIGH = 3'b010,
        ST_PAUSE = 3'b100
    } epdo_state_e;

    epdo_state_e state_q;
    logic [15:0] cnt_q;
    logic [63:0] acc_q;
    logic [15:0] eff_len;
    logic [63:0] thresh;
    logic [63:0] add;
    logic last_ms;
    logic fire;
    logic signed [32:0] epp_w;
    logic signed [32:0] pwr_w;

    // ==========================================================
    // Energy accumulation
    always_comb begin
        epp_w = 33'(pif.epp);
        pwr_w = 33'(pif.power);
        if (pif.len_ms < epdo_pkg::PULSE_LEN_MIN_MS) begin
            eff_len = epdo_pkg::PULSE_LEN_MIN_MS;
        end else if (pif.len_ms > epdo_pkg::PULSE_LEN_MAX_MS) begin
            eff_len = epdo_pkg::PULSE_LEN_MAX_MS;
        end else begin
            eff_len = pif.len_ms;
        end
        thresh = 64'(epp_w[32] ? 33'(-epp_w) : epp_w) * epdo_pkg::ENERGY_SCALE;
        add = '0;
        if (epp_w > 0 && pwr_w > 0) begin
            add = 64'(pwr_w);
        end else if (epp_w < 0 && pwr_w < 0) begin
            add = 64'(33'(-pwr_w));
        end
    end

    assign last_ms = pif.tick && (cnt_q + 16'h0001 == eff_len);
    // A pulse starts only on a tick, so its length is a whole number of ms.
    assign fire = pif.tick && (thresh != '0) && (acc_q >= thresh)
        && (state_q == ST_IDLE || (state_q == ST_PAUSE && last_ms));

    // Surplus stays in the accumulator so that delayed pulses are still issued.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else if (thresh == '0) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + (pif.tick ? add : 64'h0) - (fire ? thresh : 64'h0);
        end
    end

    // ==========================================================
    // Pulse and pause timing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (fire) begin
                        state_q <= ST_HIGH;
                        cnt_q <= '0;
                    end
                end
                ST_HIGH: begin
                    if (last_ms) begin
                        state_q <= ST_PAUSE;
                        cnt_q <= '0;
                    end else if (pif.tick) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                ST_PAUSE: begin
                    if (fire) begin
                        state_q <= ST_HIGH;
                        cnt_q <= '0;
                    end else if (last_ms) begin
                        state_q <= ST_IDLE;
                        cnt_q <= '0;
                    end else if (pif.tick) begin
                        cnt_q <= cnt_q + 16'h0001;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    assign pif.pulse = (state_q == ST_HIGH);

    // ==========================================================
    // Checks
    logic [15:0] wid_q;
    logic [15:0] gap_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wid_q <= '0;
            gap_q <= 16'hFFFF;
        end else begin
            wid_q <= !pif.pulse ? 16'h0000 : (pif.tick ? wid_q + 16'h0001 : wid_q);
            gap_q <= pif.pulse ? 16'h0000
                : ((pif.tick && gap_q != 16'hFFFF) ? gap_q + 16'h0001 : gap_q);
        end
    end

    sequence s_due;
        state_q == ST_PAUSE && last_ms && thresh != '0 && acc_q >= thresh;
    endsequence
    sequence s_restart;
        pif.pulse ##1 pif.pulse;
    endsequence

    pulse_width_a: assert property (@(posedge clk) disable iff (rst)
        $fell(pif.pulse) |-> wid_q == eff_len) else $error("pulse width wrong");
    pulse_pause_a: assert property (@(posedge clk) disable iff (rst)
        $rose(pif.pulse) |-> gap_q >= eff_len && gap_q >= 16'h000A)
        else $error("pause too short");
    len_range_a: assert property (@(posedge clk) disable iff (rst)
        pif.pulse |-> wid_q < eff_len && eff_len >= 16'h000A && eff_len <= 16'h2710)
        else $error("pulse longer than its length");
    pos_sign_a: assert property (@(posedge clk) disable iff (rst)
        (pif.tick && pif.epp > 0 && pif.power <= 0) |=> acc_q <= $past(acc_q))
        else $error("negative flow counted");
    neg_sign_a: assert property (@(posedge clk) disable iff (rst)
        (pif.tick && pif.epp < 0 && pif.power >= 0) |=> acc_q <= $past(acc_q))
        else $error("positive flow counted");
    surplus_kept_a: assert property (@(posedge clk) disable iff (rst)
        s_due |=> s_restart) else $error("deferred pulse lost");
endmodule // epdo_pulse_gen

// file: design/epdo_top.sv
// Two switching digital outputs with comparator, pulse and external sources.
// Assumes parameter accesses come from a same-clock protocol engine and
// that power values and comparator results are produced on CLOCK.
`timescale 1ns/1ps
module epdo_top #(
    parameter int CYCLES_PER_MS = epdo_pkg::CYCLES_PER_MS_DEF,
    parameter int NUM_POWER = 16
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Parameter access
    input wire logic PAR_WR,
    input wire logic PAR_RD,
    input wire logic [15:0] PAR_ADDR,
    input wire logic [15:0] PAR_WDATA,
    output logic [15:0] PAR_RDATA,
    output logic PAR_RVALID,
    output logic PAR_ERR,
    // Measurement and comparator inputs
    input wire logic [NUM_POWER*32-1:0] POWER_VALUES,
    input wire logic [1:0] CMP_RESULT,
    // External source pins
    input wire logic [1:0] EXT_IN,
    // Switching outputs
    output logic [1:0] DOUT
);
    // Refuse at elaboration the sizes that the time base and selector cannot serve.
    if (CYCLES_PER_MS < 1 || NUM_POWER < 1 || NUM_POWER > 65536) begin : g_bad_param
        $error("epdo_top: unsupported parameter value");
    end

    localparam int N = epdo_pkg::NUM_OUTPUTS;

    logic [15:0] pwr_sel_q [N];
    logic [31:0] epp_q [N];
    logic [15:0] src_q [N];
    logic [15:0] len_q;
    logic [1:0] ext_s1_q;
    logic [1:0] ext_s2_q;
    logic [31:0] ms_cnt_q;
    logic tick_q;
    logic [1:0] pulse;
    logic [1:0] dout_d;
    logic [15:0] rdata_d;
    logic hit;

    // ==========================================================
    // Millisecond time base
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ms_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (ms_cnt_q == 32'(CYCLES_PER_MS - 1)) begin
            ms_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // External source synchroniser
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            ext_s1_q <= '0;
            ext_s2_q <= '0;
        end else begin
            ext_s1_q <= EXT_IN;
            ext_s2_q <= ext_s1_q;
        end
    end

    // ==========================================================
    // Parameter writes
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < N; i++) begin
                pwr_sel_q[i] <= epdo_pkg::RST_PWR_SEL;
                epp_q[i] <= epdo_pkg::RST_EPP;
                src_q[i] <= epdo_pkg::RST_SRC;
            end
            len_q <= epdo_pkg::RST_PULSE_LEN;
        end else if (PAR_WR) begin
            case (PAR_ADDR)
                epdo_pkg::ADDR_PWR_SEL_ONE: pwr_sel_q[0] <= PAR_WDATA;
                epdo_pkg::ADDR_PWR_SEL_TWO: pwr_sel_q[1] <= PAR_WDATA;
                epdo_pkg::ADDR_EPP_ONE_HI: epp_q[0][31:16] <= PAR_WDATA;
                epdo_pkg::ADDR_EPP_ONE_LO: epp_q[0][15:0] <= PAR_WDATA;
                epdo_pkg::ADDR_EPP_TWO_HI: epp_q[1][31:16] <= PAR_WDATA;
                epdo_pkg::ADDR_EPP_TWO_LO: epp_q[1][15:0] <= PAR_WDATA;
                epdo_pkg::ADDR_PULSE_LEN: len_q <= PAR_WDATA;
                epdo_pkg::ADDR_SRC_ONE: src_q[0] <= PAR_WDATA;
                epdo_pkg::ADDR_SRC_TWO: src_q[1] <= PAR_WDATA;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // Parameter reads
    always_comb begin
        hit = 1'b1;
        rdata_d = 16'h0000;
        case (PAR_ADDR)
            epdo_pkg::ADDR_PWR_SEL_ONE: rdata_d = pwr_sel_q[0];
            epdo_pkg::ADDR_PWR_SEL_TWO: rdata_d = pwr_sel_q[1];
            epdo_pkg::ADDR_EPP_ONE_HI: rdata_d = epp_q[0][31:16];
            epdo_pkg::ADDR_EPP_ONE_LO: rdata_d = epp_q[0][15:0];
            epdo_pkg::ADDR_EPP_TWO_HI: rdata_d = epp_q[1][31:16];
            epdo_pkg::ADDR_EPP_TWO_LO: rdata_d = epp_q[1][15:0];
            epdo_pkg::ADDR_PULSE_LEN: rdata_d = len_q;
            epdo_pkg::ADDR_SRC_ONE: rdata_d = src_q[0];
            epdo_pkg::ADDR_SRC_TWO: rdata_d = src_q[1];
            epdo_pkg::ADDR_STATE_ONE: rdata_d = {15'h0000, DOUT[0]};
            epdo_pkg::ADDR_STATE_TWO: rdata_d = {15'h0000, DOUT[1]};
            default: hit = 1'b0;
        endcase
    end

    // Writes to the state words are refused like unmapped addresses.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            PAR_RDATA <= '0;
            PAR_RVALID <= 1'b0;
            PAR_ERR <= 1'b0;
        end else begin
            PAR_RVALID <= PAR_RD;
            PAR_RDATA <= PAR_RD ? rdata_d : PAR_RDATA;
            PAR_ERR <= (PAR_RD && !hit) || (PAR_WR && (!hit
                || PAR_ADDR == epdo_pkg::ADDR_STATE_ONE
                || PAR_ADDR == epdo_pkg::ADDR_STATE_TWO));
        end
    end

    // ==========================================================
    // Pulse generators and output routing
    for (genvar g = 0; g < N; g++) begin : g_out
        epdo_pulse_if pif ();
        logic signed [31:0] pwr;

        // An out-of-range selection delivers no power, so no energy accrues.
        always_comb begin
            pwr = '0;
            for (int k = 0; k < NUM_POWER; k++) begin
                if (32'(pwr_sel_q[g]) == 32'(k)) begin
                    pwr = POWER_VALUES[k*32 +: 32];
                end
            end
        end

        assign pif.tick = tick_q;
        assign pif.power = pwr;
        assign pif.epp = epp_q[g];
        assign pif.len_ms = len_q;
        assign pulse[g] = pif.pulse;

        epdo_pulse_gen u_gen (
            .clk(CLOCK),
            .rst(RST),
            .pif(pif.gen)
        );

        always_comb begin
            case (src_q[g])
                epdo_pkg::SRC_COMPARATOR: dout_d[g] = CMP_RESULT[g];
                epdo_pkg::SRC_PULSE: dout_d[g] = pulse[g];
                epdo_pkg::SRC_EXTERNAL: dout_d[g] = ext_s2_q[g];
                default: dout_d[g] = 1'b0;
            endcase
        end
    end

    // Each output is driven from its own flop, independent of the other.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            DOUT <= '0;
        end else begin
            DOUT <= dout_d;
        end
    end

    // ==========================================================
    // Checks
    sequence s_read(logic [15:0] a);
        PAR_RD && PAR_ADDR == a;
    endsequence

    cmp_route_a: assert property (@(posedge CLOCK) disable iff (RST)
        src_q[0] == epdo_pkg::SRC_COMPARATOR |=> DOUT[0] == $past(CMP_RESULT[0]))
        else $error("comparator not routed");
    ext_route_a: assert property (@(posedge CLOCK) disable iff (RST)
        (src_q[1] == epdo_pkg::SRC_EXTERNAL && $stable(src_q[1]))
        |=> DOUT[1] == $past(EXT_IN[1], 3)) else $error("external not routed");
    pulse_route_a: assert property (@(posedge CLOCK) disable iff (RST)
        src_q[1] == epdo_pkg::SRC_PULSE |=> DOUT[1] == $past(pulse[1]))
        else $error("pulse not routed");
    state_read_a: assert property (@(posedge CLOCK) disable iff (RST)
        s_read(epdo_pkg::ADDR_STATE_ONE) |=> PAR_RVALID && PAR_RDATA == {15'h0000, $past(DOUT[0])})
        else $error("state word wrong");
endmodule // epdo_top

// file: sim/epdo_pulse_rx.sv
// Behavioural pulse receiver watching one switching output.
// Assumes the output is sampled on the block's own clock.
`timescale 1ns/1ps
module epdo_pulse_rx (
    // Clock and control
    input wire logic clk,
    input wire logic clr,
    // Watched output
    input wire logic din,
    // Measurements, widths in clock cycles
    output int cnt,
    output int hi_w,
    output int lo_min
);
    // ==========================================================
    // Edge and width measurement
    logic prev;
    logic seen;
    int run;
    // Counts rising edges and the width of each level, as a meter input would.
    always_ff @(posedge clk) begin
        prev <= din;
        run <= (din != prev) ? 1 : run + 1;
        if (clr) begin
            cnt <= 0;
            hi_w <= 0;
            lo_min <= 32'h7FFFFFFF;
            seen <= 1'b0;
        end else if (din && !prev) begin
            cnt <= cnt + 1;
            if (seen && run < lo_min) begin
                lo_min <= run;
            end
        end else if (!din && prev) begin
            hi_w <= run;
            seen <= 1'b1;
        end
    end
endmodule // epdo_pulse_rx

// file: sim/test_energy_pulse_digital_outputs.sv
// Self-checking bench for the two switching outputs and their pulse generators.
// Assumes a shortened millisecond of four clock cycles.
`timescale 1ns/1ps
module test_energy_pulse_digital_outputs;
    localparam int CPM = 4;
    localparam int L10 = 10 * CPM;
    logic CLOCK;
    logic RST;
    logic PAR_WR;
    logic PAR_RD;
    logic [15:0] PAR_ADDR;
    logic [15:0] PAR_WDATA;
    logic [15:0] PAR_RDATA;
    logic PAR_RVALID;
    logic PAR_ERR;
    logic [127:0] POWER_VALUES;
    logic [1:0] CMP_RESULT;
    logic [1:0] EXT_IN;
    logic [1:0] DOUT;
    logic rx_clr;
    int rc [2];
    int rh [2];
    int rm [2];
    int bad_count;
    int n_compared;

    epdo_top #(.CYCLES_PER_MS(CPM), .NUM_POWER(4)) dut (
        .CLOCK(CLOCK), .RST(RST), .PAR_WR(PAR_WR), .PAR_RD(PAR_RD),
        .PAR_ADDR(PAR_ADDR), .PAR_WDATA(PAR_WDATA), .PAR_RDATA(PAR_RDATA),
        .PAR_RVALID(PAR_RVALID), .PAR_ERR(PAR_ERR), .POWER_VALUES(POWER_VALUES),
        .CMP_RESULT(CMP_RESULT), .EXT_IN(EXT_IN), .DOUT(DOUT)
    );
    for (genvar i = 0; i < 2; i++) begin : g_rx
        epdo_pulse_rx u_rx (.clk(CLOCK), .clr(rx_clr), .din(DOUT[i]),
            .cnt(rc[i]), .hi_w(rh[i]), .lo_min(rm[i]));
    end

    // ==========================================================
    // Checks and bus cycles
    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi, input string what);
        n_compared++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %0d expected %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic err);
        @(negedge CLOCK);
        PAR_WR = 1'b1;
        PAR_ADDR = a;
        PAR_WDATA = d;
        @(negedge CLOCK);
        PAR_WR = 1'b0;
        chk_eq({31'h0, PAR_ERR}, {31'h0, err}, "write error flag");
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err);
        @(negedge CLOCK);
        PAR_RD = 1'b1;
        PAR_ADDR = a;
        @(negedge CLOCK);
        PAR_RD = 1'b0;
        chk_eq({31'h0, PAR_RVALID}, 32'h1, "read valid");
        chk_eq({31'h0, PAR_ERR}, {31'h0, err}, "read error flag");
        chk_eq({16'h0, PAR_RDATA}, {16'h0, exp}, "read data");
    endtask
    task automatic epp(input logic [15:0] hi, input logic [31:0] v);
        wr(hi, v[31:16], 1'b0);
        wr(hi + 16'h0001, v[15:0], 1'b0);
    endtask
    task automatic run_ms(input int n);
        repeat (n * CPM) @(negedge CLOCK);
    endtask
    task automatic setp(input int k, input int w);
        POWER_VALUES[32*k +: 32] = w;
    endtask
    task automatic clr_rx;
        rx_clr = 1'b1;
        @(negedge CLOCK);
        rx_clr = 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        chk_eq({30'h0, DOUT}, 32'h0, "outputs after reset");
        rd(epdo_pkg::ADDR_PWR_SEL_ONE, 16'h0000, 1'b0);
        rd(epdo_pkg::ADDR_EPP_TWO_LO, 16'h0000, 1'b0);
        rd(epdo_pkg::ADDR_PULSE_LEN, 16'h001E, 1'b0);
        rd(epdo_pkg::ADDR_SRC_TWO, 16'h0000, 1'b0);
        wr(epdo_pkg::ADDR_PWR_SEL_TWO, 16'h0001, 1'b0);
        rd(epdo_pkg::ADDR_PWR_SEL_TWO, 16'h0001, 1'b0);
        rd(16'h0070, 16'h0000, 1'b1);
        wr(epdo_pkg::ADDR_STATE_ONE, 16'h0001, 1'b1);
        rd(epdo_pkg::ADDR_STATE_ONE, 16'h0000, 1'b0);
    endtask
    task automatic t_route;
        CMP_RESULT = 2'b01;
        @(negedge CLOCK);
        chk_eq({30'h0, DOUT}, 32'h1, "comparator routing");
        rd(epdo_pkg::ADDR_STATE_ONE, 16'h0001, 1'b0);
        wr(epdo_pkg::ADDR_SRC_TWO, epdo_pkg::SRC_EXTERNAL, 1'b0);
        EXT_IN = 2'b10;
        repeat (2) @(negedge CLOCK);
        chk_eq({31'h0, DOUT[1]}, 32'h0, "external too early");
        @(negedge CLOCK);
        chk_eq({30'h0, DOUT}, 32'h3, "external routing");
        rd(epdo_pkg::ADDR_STATE_TWO, 16'h0001, 1'b0);
        wr(epdo_pkg::ADDR_SRC_ONE, 16'h0003, 1'b0);
        repeat (2) @(negedge CLOCK);
        chk_eq({31'h0, DOUT[0]}, 32'h0, "undefined source");
        CMP_RESULT = 2'b00;
        EXT_IN = 2'b00;
    endtask
    task automatic t_shape;
        wr(epdo_pkg::ADDR_SRC_ONE, epdo_pkg::SRC_PULSE, 1'b0);
        wr(epdo_pkg::ADDR_PULSE_LEN, 16'h0005, 1'b0);
        epp(epdo_pkg::ADDR_EPP_ONE_HI, 32'h00000001);
        setp(0, 7200);
        clr_rx();
        run_ms(200);
        chk_in(rc[0], 9, 10, "pulses under surplus");
        chk_in(rh[0], L10, L10, "pulse width clamped");
        chk_in(rm[0], L10, L10, "pause with surplus");
        setp(0, 0);
        clr_rx();
        run_ms(100);
        chk_in(rc[0], 4, 5, "deferred pulses");
        epp(epdo_pkg::ADDR_EPP_ONE_HI, 32'h00000000);
        run_ms(30);
        clr_rx();
        run_ms(60);
        chk_in(rc[0], 0, 0, "zero pulse value");
    endtask
    task automatic t_rate;
        wr(epdo_pkg::ADDR_PULSE_LEN, 16'h000A, 1'b0);
        epp(epdo_pkg::ADDR_EPP_ONE_HI, 32'h00000001);
        setp(0, 60);
        clr_rx();
        run_ms(600);
        chk_in(rc[0], 9, 10, "pulses at low power");
        setp(0, 120);
        clr_rx();
        run_ms(600);
        chk_in(rc[0], 19, 21, "pulses at double power");
        chk_in(rm[0], 19 * CPM, 21 * CPM, "pause follows power");
    endtask
    task automatic t_sign;
        wr(epdo_pkg::ADDR_SRC_TWO, epdo_pkg::SRC_PULSE, 1'b0);
        epp(epdo_pkg::ADDR_EPP_TWO_HI, 32'hFFFFFFFF);
        setp(1, -120);
        clr_rx();
        run_ms(300);
        chk_in(rc[0], 9, 11, "positive value, positive flow");
        chk_in(rc[1], 9, 10, "negative value, negative flow");
        setp(0, -120);
        setp(1, 120);
        run_ms(40);
        clr_rx();
        run_ms(300);
        chk_in(rc[0], 0, 0, "positive value, negative flow");
        chk_in(rc[1], 0, 0, "negative value, positive flow");
    endtask

    // ==========================================================
    // Clock, run and verdict
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end
    initial begin
        repeat (60000) @(posedge CLOCK);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        bad_count = 0;
        n_compared = 0;
        RST = 1'b1;
        PAR_WR = 1'b0;
        PAR_RD = 1'b0;
        PAR_ADDR = 16'h0000;
        PAR_WDATA = 16'h0000;
        POWER_VALUES = '0;
        CMP_RESULT = 2'b00;
        EXT_IN = 2'b00;
        rx_clr = 1'b1;
        repeat (3) @(negedge CLOCK);
        RST = 1'b0;
        rx_clr = 1'b0;
        t_regs();
        t_route();
        t_shape();
        t_rate();
        t_sign();
        stop_test();
    end
endmodule // test_energy_pulse_digital_outputs
